// ### hw/sltp_cfg.svh
// Function
// RQ1 - Clock pattern bypasses both layers: neither scrambled nor encoded.
// RQ2 - Clock pattern sends eight ones then eight zeros, repeated forever.
// RQ3 - Ramp keeps link layer normal, transport off, sample input ignored.
// RQ4 - Ramp starts after alignment (8b/10b) or serializer init (64b/66b).
// RQ5 - Ramp octet stream is identical on all lanes, encoded and scrambled.
// RQ6 - Ramp counts from 0x00 each multiframe, wrapping after 0xFF.
// RQ7 - Ramp works with both 8b/10b and 64b/66b encoding.
// RQ8 - Transport patterns begin after link start and repeat in data state.
// RQ9 - All lane modes use the short transport pattern, repeated per frame; the 8-bit pattern repeats every two frames.
// RQ10 - 8-bit short pattern: lane i sends i, then 0xFF minus i.
// RQ11 - Only the lowest enabled lanes carry the pattern; others stay idle.
// RQ12 - 12-bit pattern: words with nibbles 0xF-j, j, k on each lane.
// RQ13 - D21.5 mode sends a continuous D21.5 stream with either encoding.
// RQ14 - K28.5 mode sends continuous K28.5 commas, 8b/10b only.
// RQ15 - Repeated alignment mode resends alignment, never enters data phase.
// RQ16 - Repeated alignment: on sync request do code group sync, then resume.
// RQ17 - Modified RPAT repeats a 12-octet pattern starting 0xBE, 0xD7.
// RQ18 - RPAT octets three to twelve follow the fixed table order.
// RQ19 - Controller selects a test mode only while the link is disabled.
// RQ20 - The 12-bit pattern tail nibble is driven as zero.
`ifndef SLTP_CFG_SVH
`define SLTP_CFG_SVH

`define SLTP_NUM_LANES 16
`define SLTP_MODE_OFF 4'h0
`define SLTP_MODE_CLOCK 4'h1
`define SLTP_MODE_RAMP 4'h2
`define SLTP_MODE_STP 4'h3
`define SLTP_MODE_D215 4'h4
`define SLTP_MODE_K285 4'h5
`define SLTP_MODE_RILA 4'h6
`define SLTP_MODE_RPAT 4'h7

`define SLTP_CLK_ONES 8'hff
`define SLTP_CLK_ZEROS 8'h00
`define SLTP_D215 8'hb5
`define SLTP_K285 8'hbc
`define SLTP_RAMP_START 8'h00
`define SLTP_STP8_TOP 8'hff
`define SLTP_GRP8_MASK 4'h3
`define SLTP_GRP12_MASK 4'h7
`define SLTP_NIB_TOP 4'hf
`define SLTP_NIB_TAIL 4'hf
`define SLTP_TAIL_VALUE 4'h0

`define SLTP_RPAT_LAST 4'hb
`define SLTP_RPAT0 8'hbe
`define SLTP_RPAT1 8'hd7
`define SLTP_RPAT2 8'h23
`define SLTP_RPAT3 8'h47
`define SLTP_RPAT4 8'h6b
`define SLTP_RPAT5 8'h8f
`define SLTP_RPAT6 8'hb3
`define SLTP_RPAT7 8'h14
`define SLTP_RPAT8 8'h5e
`define SLTP_RPAT9 8'hfb
`define SLTP_RPAT10 8'h35
`define SLTP_RPAT11 8'h59

`endif

// ### hw/sltp_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "sltp_cfg.svh"
// Lane test-pattern source. Each cycle every lane gets one octet. The
// flags tell the link layer whether to bypass transport, bypass the
// whole link layer, treat the octet as a control character, or run its
// own alignment sequence instead of data.
module sltp_gen (
   input wire logic clk,                   // 25 MHz system clock
   input wire logic rst,                   // Synchronous reset
   input wire logic [3:0] testPatternSelect, // Requested test mode
   input wire logic linkEnable,            // Link running; mode is frozen
   input wire logic encode64b66b,          // 1: 64b/66b, 0: 8b/10b
   input wire logic [4:0] laneCount,       // Enabled lanes, 0 to 16
   input wire logic sample12,              // 1: 12-bit, 0: 8-bit samples
   input wire logic [3:0] octetsPerFrameM1, // F minus one
   input wire logic [7:0] framesPerMfM1,   // K minus one
   input wire logic ilaDone,               // Alignment done, data state
   input wire logic serdesReady,           // Serializers initialised
   input wire logic syncRequestN,          // Receiver sync pin, low active
   output logic [127:0] laneData,          // Octet per lane, lane 0 low
   output logic [15:0] laneIsCtrl,         // Octet is a control char
   output logic [15:0] laneValid,          // Lane carries pattern
   output logic bypassLink,                // Skip scrambler and encoder
   output logic bypassTransport,           // Ignore formatter samples
   output logic ilaRepeat,                 // Link resends alignment only
   output logic cgsRequest,                // Link performs code group sync
   output logic patternActive              // Pattern is being sent
);
   sltp_pos_if pos ();

   sltp_pos_cnt u_pos (
      .clk(clk),
      .rst(rst),
      .pos(pos)
   );

   // Nibble of the 12-bit short pattern for lane j at position n
   function automatic logic [3:0] stp12Nibble(
      input logic [2:0] j,
      input logic [3:0] n
   );
      logic [3:0] word;
      logic [1:0] part;
      word = 4'h0;
      part = 2'h0;
      stp12Nibble = `SLTP_TAIL_VALUE;
      if (n != `SLTP_NIB_TAIL) begin
         word = 4'((n / 4'h3) + 4'h1);
         part = 2'(n % 4'h3);
         case (part)
            2'h0: stp12Nibble = `SLTP_NIB_TOP - {1'b0, j}; // see RQ12
            2'h1: stp12Nibble = {1'b0, j}; // see RQ12
            default: stp12Nibble = word; // see RQ12
         endcase
      end else begin
         stp12Nibble = `SLTP_TAIL_VALUE; // see RQ20
      end
   endfunction

   function automatic sltp_pkg::sltp_octet_t stp12Octet(
      input logic [2:0] j,
      input logic [3:0] octet
   );
      stp12Octet = {stp12Nibble(j, {octet[2:0], 1'b0}),
                    stp12Nibble(j, {octet[2:0], 1'b1})};
   endfunction

   function automatic sltp_pkg::sltp_octet_t stp8Octet(
      input logic [1:0] i,
      input logic frameOdd
   );
      if (frameOdd) begin
         stp8Octet = `SLTP_STP8_TOP - {6'h00, i}; // see RQ10
      end else begin
         stp8Octet = {6'h00, i}; // see RQ10
      end
   endfunction

   function automatic sltp_pkg::sltp_octet_t rpatOctet(
      input logic [3:0] idx
   );
      case (idx)
         4'h0: rpatOctet = `SLTP_RPAT0; // see RQ17
         4'h1: rpatOctet = `SLTP_RPAT1; // see RQ17
         4'h2: rpatOctet = `SLTP_RPAT2; // see RQ18
         4'h3: rpatOctet = `SLTP_RPAT3;
         4'h4: rpatOctet = `SLTP_RPAT4;
         4'h5: rpatOctet = `SLTP_RPAT5;
         4'h6: rpatOctet = `SLTP_RPAT6;
         4'h7: rpatOctet = `SLTP_RPAT7;
         4'h8: rpatOctet = `SLTP_RPAT8;
         4'h9: rpatOctet = `SLTP_RPAT9;
         4'ha: rpatOctet = `SLTP_RPAT10;
         4'hb: rpatOctet = `SLTP_RPAT11; // see RQ18
         default: rpatOctet = `SLTP_RPAT0;
      endcase
   endfunction

   // Modes tied to 8b/10b are refused under 64b/66b; unknown codes too
   function automatic logic modeSupported(
      input sltp_pkg::sltp_mode_t m,
      input logic enc66
   );
      case (m)
         `SLTP_MODE_OFF,
         `SLTP_MODE_CLOCK,
         `SLTP_MODE_RAMP,
         `SLTP_MODE_STP,
         `SLTP_MODE_D215: modeSupported = 1'b1; // see RQ7 RQ13
         `SLTP_MODE_K285,
         `SLTP_MODE_RILA,
         `SLTP_MODE_RPAT: modeSupported = !enc66; // see RQ14 RQ17
         default: modeSupported = 1'b0;
      endcase
   endfunction

   // Ramp and transport patterns hold off until the link is up
   function automatic logic waitsForLink(
      input sltp_pkg::sltp_mode_t m
   );
      waitsForLink = (m == `SLTP_MODE_RAMP) || (m == `SLTP_MODE_STP);
   endfunction

   // Sync request pin crossing
   logic syncMeta;
   logic syncReqN;
   logic next_syncMeta;
   logic next_syncReqN;

   always_comb begin
      next_syncMeta = syncRequestN;
      next_syncReqN = syncMeta;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         syncMeta <= 1'b1;
         syncReqN <= 1'b1;
      end else begin
         syncMeta <= next_syncMeta;
         syncReqN <= next_syncReqN;
      end
   end

   // Mode capture and sequencing
   sltp_pkg::sltp_mode_t mode;
   sltp_pkg::sltp_state_e state;
   sltp_pkg::sltp_mode_t next_mode;
   sltp_pkg::sltp_state_e next_state;
   logic needsLinkStart;
   logic started;
   logic supported;

   always_comb begin
      next_mode = mode;
      next_state = state;
      needsLinkStart = waitsForLink(mode);
      // Link is up: alignment done, or serializers ready for 64b/66b
      started = encode64b66b ? serdesReady : ilaDone; // see RQ4 RQ8
      supported = modeSupported(mode, encode64b66b);
      if (!linkEnable) begin
         next_mode = testPatternSelect; // see RQ19
      end
      case (state)
         sltp_pkg::ST_OFF: begin
            if (mode != `SLTP_MODE_OFF && supported) begin
               next_state = sltp_pkg::ST_WAIT;
            end
         end
         sltp_pkg::ST_WAIT: begin
            if (mode == `SLTP_MODE_OFF || !supported) begin
               next_state = sltp_pkg::ST_OFF;
            end else if (!needsLinkStart || started) begin
               next_state = sltp_pkg::ST_RUN;
            end
         end
         sltp_pkg::ST_RUN: begin
            if (mode == `SLTP_MODE_OFF || !supported) begin
               next_state = sltp_pkg::ST_OFF;
            end else if (needsLinkStart && !encode64b66b && !ilaDone) begin
               next_state = sltp_pkg::ST_WAIT; // see RQ8
            end else if (mode == `SLTP_MODE_RILA && !syncReqN) begin
               next_state = sltp_pkg::ST_CGS; // see RQ16
            end
         end
         // Hold code group sync until the receiver drops its request
         sltp_pkg::ST_CGS: begin
            if (mode != `SLTP_MODE_RILA) begin
               next_state = sltp_pkg::ST_OFF;
            end else if (syncReqN) begin
               next_state = sltp_pkg::ST_RUN; // see RQ16
            end
         end
         default: next_state = sltp_pkg::ST_OFF;
      endcase
      // Any mode change restarts the sequence from OFF
      if (next_mode != mode) begin
         next_state = sltp_pkg::ST_OFF;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mode <= `SLTP_MODE_OFF;
         state <= sltp_pkg::ST_OFF;
      end else begin
         mode <= next_mode;
         state <= next_state;
      end
   end

   // Position counters advance only while the pattern runs
   assign pos.run = (state == sltp_pkg::ST_RUN);
   assign pos.octetsPerFrameM1 = octetsPerFrameM1;
   assign pos.framesPerMfM1 = framesPerMfM1;

   // Pattern phase: clock half-word and RPAT octet index. Both restart
   // from their first unit every time the run state is entered.
   logic clkPhase;
   logic [3:0] rpatIdx;
   logic next_clkPhase;
   logic [3:0] next_rpatIdx;

   always_comb begin
      next_clkPhase = 1'b0;
      next_rpatIdx = 4'h0;
      if (state == sltp_pkg::ST_RUN) begin
         next_clkPhase = ~clkPhase; // see RQ2
         if (rpatIdx == `SLTP_RPAT_LAST) begin
            next_rpatIdx = 4'h0; // see RQ17
         end else begin
            next_rpatIdx = rpatIdx + 4'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         clkPhase <= 1'b0;
         rpatIdx <= 4'h0;
      end else begin
         clkPhase <= next_clkPhase;
         rpatIdx <= next_rpatIdx;
      end
   end

   // Lane outputs
   logic [127:0] next_laneData;
   logic [15:0] next_laneIsCtrl;
   logic [15:0] next_laneValid;
   logic next_bypassLink;
   logic next_bypassTransport;
   logic next_ilaRepeat;
   logic next_cgsRequest;
   logic next_patternActive;

   always_comb begin
      logic running;
      logic [3:0] lane;
      sltp_pkg::sltp_octet_t octet;
      logic ctrl;
      running = (state == sltp_pkg::ST_RUN);
      lane = 4'h0;
      octet = 8'h00;
      ctrl = 1'b0;
      next_laneData = 128'h0;
      next_laneIsCtrl = 16'h0000;
      next_laneValid = 16'h0000;
      next_bypassLink = running && (mode == `SLTP_MODE_CLOCK); // see RQ1
      // Formatter samples are ignored in every active pattern mode except repeated alignment
      next_bypassTransport = running && (mode != `SLTP_MODE_RILA); // see RQ3
      next_ilaRepeat = (state != sltp_pkg::ST_OFF) &&
                       (mode == `SLTP_MODE_RILA); // see RQ15
      next_cgsRequest = (state == sltp_pkg::ST_CGS); // see RQ16
      next_patternActive = running;
      for (int l = 0; l < `SLTP_NUM_LANES; l++) begin
         lane = 4'(l);
         octet = 8'h00;
         ctrl = 1'b0;
         case (mode)
            `SLTP_MODE_CLOCK: begin
               octet = clkPhase ? `SLTP_CLK_ZEROS : `SLTP_CLK_ONES; // see RQ2
            end
            `SLTP_MODE_RAMP: begin
               octet = pos.mfOctet; // see RQ5 RQ6 RQ7
            end
            `SLTP_MODE_STP: begin
               if (sample12) begin
                  octet = stp12Octet(3'(lane & `SLTP_GRP12_MASK),
                                     pos.octetIdx); // see RQ9 RQ12
               end else begin
                  octet = stp8Octet(2'(lane & `SLTP_GRP8_MASK),
                                    pos.frameIdx[0]); // see RQ9 RQ10
               end
            end
            `SLTP_MODE_D215: begin
               octet = `SLTP_D215; // see RQ13
            end
            `SLTP_MODE_K285: begin
               octet = `SLTP_K285; // see RQ14
               ctrl = 1'b1;
            end
            `SLTP_MODE_RPAT: begin
               octet = rpatOctet(rpatIdx); // see RQ17 RQ18
            end
            default: begin
               octet = 8'h00;
               ctrl = 1'b0;
            end
         endcase
         // Lanes beyond the configured count stay silent
         if (running && mode != `SLTP_MODE_RILA &&
             5'(l) < laneCount) begin // see RQ11
            next_laneData[8*l +: 8] = octet;
            next_laneIsCtrl[l] = ctrl;
            next_laneValid[l] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         laneData <= 128'h0;
         laneIsCtrl <= 16'h0000;
         laneValid <= 16'h0000;
         bypassLink <= 1'b0;
         bypassTransport <= 1'b0;
         ilaRepeat <= 1'b0;
         cgsRequest <= 1'b0;
         patternActive <= 1'b0;
      end else begin
         laneData <= next_laneData;
         laneIsCtrl <= next_laneIsCtrl;
         laneValid <= next_laneValid;
         bypassLink <= next_bypassLink;
         bypassTransport <= next_bypassTransport;
         ilaRepeat <= next_ilaRepeat;
         cgsRequest <= next_cgsRequest;
         patternActive <= next_patternActive;
      end
   end
endmodule
`default_nettype wire

// ### hw/sltp_pkg.sv
package sltp_pkg;
   typedef logic [3:0] sltp_mode_t;
   typedef logic [7:0] sltp_octet_t;
   typedef enum logic [1:0] {
      ST_OFF,
      ST_WAIT,
      ST_RUN,
      ST_CGS
   } sltp_state_e;
endpackage

// ### hw/sltp_pos_cnt.sv
`timescale 1ns/1ps
`default_nettype none
`include "sltp_cfg.svh"
// Tracks the octet inside the frame, the frame inside the multiframe
// and a running octet count that restarts on every multiframe.
module sltp_pos_cnt (
   input wire logic clk,        // System clock
   input wire logic rst,        // Synchronous reset
   sltp_pos_if.cnt pos          // Position counters
);
   logic [3:0] next_octetIdx;
   logic [7:0] next_frameIdx;
   logic [7:0] next_mfOctet;

   always_comb begin
      next_octetIdx = pos.octetIdx;
      next_frameIdx = pos.frameIdx;
      next_mfOctet = pos.mfOctet;
      if (!pos.run) begin
         next_octetIdx = 4'h0;
         next_frameIdx = 8'h00;
         next_mfOctet = `SLTP_RAMP_START;
      end else if (pos.octetIdx == pos.octetsPerFrameM1) begin
         next_octetIdx = 4'h0;
         if (pos.frameIdx == pos.framesPerMfM1) begin
            next_frameIdx = 8'h00;
            next_mfOctet = `SLTP_RAMP_START; // see RQ6
         end else begin
            next_frameIdx = pos.frameIdx + 8'h01;
            next_mfOctet = pos.mfOctet + 8'h01;
         end
      end else begin
         next_octetIdx = pos.octetIdx + 4'h1;
         next_mfOctet = pos.mfOctet + 8'h01; // see RQ6
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pos.octetIdx <= 4'h0;
         pos.frameIdx <= 8'h00;
         pos.mfOctet <= 8'h00;
      end else begin
         pos.octetIdx <= next_octetIdx;
         pos.frameIdx <= next_frameIdx;
         pos.mfOctet <= next_mfOctet;
      end
   end
endmodule
`default_nettype wire

// ### hw/sltp_pos_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sltp_pos_if;
   logic run;
   logic [3:0] octetsPerFrameM1;
   logic [7:0] framesPerMfM1;
   logic [3:0] octetIdx;
   logic [7:0] frameIdx;
   logic [7:0] mfOctet;
   modport ctl (
      output run,
      output octetsPerFrameM1,
      output framesPerMfM1,
      input octetIdx,
      input frameIdx,
      input mfOctet
   );
   modport cnt (
      input run,
      input octetsPerFrameM1,
      input framesPerMfM1,
      output octetIdx,
      output frameIdx,
      output mfOctet
   );
endinterface
`default_nettype wire

// ### tb/sltp_gen_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sltp_cfg.svh"
module sltp_gen_tb;
   typedef struct {logic [127:0] d; logic [15:0] v, k; logic bl;} sltp_exp_s;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] sel = 4'h0;
   logic linkEn = 1'b0, enc66 = 1'b0, s12 = 1'b0, loseSync = 1'b0;
   logic ilaDone = 1'b0, serdesReady = 1'b0, armed = 1'b0;
   logic [4:0] lanes = 5'h10;
   logic [3:0] fm1 = 4'h0;
   logic [7:0] km1 = 8'h0;
   logic syncN;
   logic [127:0] laneData;
   logic [15:0] laneIsCtrl, laneValid;
   logic bypassLink, bypassTransport, ilaRepeat, cgsRequest, patternActive;
   int errors = 0, compares = 0;
   logic [31:0] rng = 32'd25;
   logic [7:0] rpat [12] = '{8'hbe, 8'hd7, 8'h23, 8'h47, 8'h6b, 8'h8f,
      8'hb3, 8'h14, 8'h5e, 8'hfb, 8'h35, 8'h59};
   sltp_exp_s expq[$];

   always #20 clk = ~clk;

   sltp_gen dut_u (.clk(clk), .rst(rst), .testPatternSelect(sel),
      .linkEnable(linkEn), .encode64b66b(enc66), .laneCount(lanes),
      .sample12(s12), .octetsPerFrameM1(fm1), .framesPerMfM1(km1),
      .ilaDone(ilaDone), .serdesReady(serdesReady), .syncRequestN(syncN),
      .laneData(laneData), .laneIsCtrl(laneIsCtrl), .laneValid(laneValid),
      .bypassLink(bypassLink), .bypassTransport(bypassTransport),
      .ilaRepeat(ilaRepeat), .cgsRequest(cgsRequest),
      .patternActive(patternActive));
   sltp_rx_model rx_u (.clk(clk), .loseSync(loseSync), .syncRequestN(syncN));

   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   function automatic logic [3:0] nib(input int n, input int j);
      if (n == 15) return 4'h0;
      case (n % 3)
         0: return 4'(15 - j);
         1: return 4'(j);
         default: return 4'(n / 3 + 1);
      endcase
   endfunction

   function automatic logic [7:0] octet(input logic [3:0] m, input int n,
      input int l);
      int f, fr;
      f = fm1 + 1;
      // Frame parity restarts with every multiframe
      fr = (n / f) % (km1 + 1);
      case (m)
         `SLTP_MODE_CLOCK: return (n % 2) ? 8'h00 : 8'hff;
         `SLTP_MODE_RAMP: return 8'(n % (f * (km1 + 1)));
         `SLTP_MODE_D215: return 8'hb5;
         `SLTP_MODE_K285: return 8'hbc;
         `SLTP_MODE_RPAT: return rpat[n % 12];
         default: ;
      endcase
      if (!s12) return fr[0] ? 8'(255 - l % 4) : 8'(l % 4);
      return {nib(2 * (n % 8), l % 8),
              nib(2 * (n % 8) + 1, l % 8)};
   endfunction

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic cmp(input logic [127:0] got, input logic [127:0] exp,
      input string what);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   always @(negedge clk) begin
      logic [127:0] m;
      sltp_exp_s e;
      if (armed && patternActive === 1'b1) begin
         e = expq.pop_front();
         for (int l = 0; l < 16; l++) m[8*l +: 8] = {8{e.v[l]}};
         cmp(laneData & m, e.d & m, "data");
         cmp(128'(laneValid), 128'(e.v), "valid");
         cmp(128'(laneIsCtrl & e.v), 128'(e.k), "ctrl");
         cmp(128'({bypassLink, bypassTransport}),
             128'({e.bl, 1'b1}), "byp");
         if (expq.size() == 0) armed = 1'b0;
      end
   end

   task automatic run_mode(input logic [3:0] m, input int cnt);
      sltp_exp_s e;
      int t;
      ilaDone = 1'b0;
      serdesReady = 1'b0;
      sel = m;
      for (int n = 0; n < cnt; n++) begin
         e.v = 16'((17'h1 << lanes) - 17'h1);
         e.k = (m == `SLTP_MODE_K285) ? e.v : 16'h0;
         e.bl = (m == `SLTP_MODE_CLOCK);
         for (int l = 0; l < 16; l++) e.d[8*l +: 8] = octet(m, n, l);
         expq.push_back(e);
      end
      armed = 1'b1;
      tick(2);
      linkEn = 1'b1;
      sel = ~m;
      tick(6);
      if (m == `SLTP_MODE_RAMP || m == `SLTP_MODE_STP)
         cmp(128'(patternActive), 128'h0, "gate");
      if (enc66) serdesReady = 1'b1;
      else ilaDone = 1'b1;
      t = 0;
      while (armed && t < cnt + 20) begin
         tick(1);
         t++;
      end
      cmp(128'(armed), 128'h0, "stalled");
      armed = 1'b0;
      expq.delete();
      linkEn = 1'b0;
      sel = `SLTP_MODE_OFF;
      tick(4);
   endtask

   task automatic close_out();
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      #(40 * 20000);
      errors++;
      close_out();
   end

   initial begin
      tick(2);
      rst = 1'b0;
      for (int r = 0; r < 8; r++) begin
         lanes = 5'(xs() % 16 + 1);
         km1 = 8'(xs() % 16);
         fm1 = 4'(xs() % 4);
         enc66 = 1'(r % 2);
         run_mode(`SLTP_MODE_D215, 6);
         run_mode(`SLTP_MODE_RAMP, 40);
         run_mode(`SLTP_MODE_STP, 12);
      end
      enc66 = 1'b0;
      run_mode(`SLTP_MODE_CLOCK, 8);
      run_mode(`SLTP_MODE_K285, 6);
      run_mode(`SLTP_MODE_RPAT, 30);
      s12 = 1'b1;
      fm1 = 4'h7;
      lanes = 5'h10;
      run_mode(`SLTP_MODE_STP, 24);
      s12 = 1'b0;
      fm1 = 4'h1;
      km1 = 8'd199;
      run_mode(`SLTP_MODE_RAMP, 420);
      sel = `SLTP_MODE_RILA;
      tick(2);
      linkEn = 1'b1;
      ilaDone = 1'b1;
      tick(6);
      cmp(128'({ilaRepeat, laneValid}), 128'h10000, "rila");
      loseSync = 1'b1;
      tick(8);
      cmp(128'(cgsRequest), 128'h1, "cgs");
      loseSync = 1'b0;
      tick(8);
      cmp(128'({cgsRequest, ilaRepeat}), 128'h1, "resume");
      linkEn = 1'b0;
      enc66 = 1'b1;
      for (int m = 5; m < 9; m++) begin
         sel = 4'(m);
         tick(2);
         linkEn = 1'b1;
         serdesReady = 1'b1;
         tick(8);
         cmp(128'({patternActive, laneValid}), 128'h0, "refused");
         linkEn = 1'b0;
         tick(2);
      end
      close_out();
   end
endmodule
`default_nettype wire

// ### tb/sltp_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sltp_monitor (
   input wire logic clk, // Clock
   input wire logic rst, // Reset
   input wire logic linkEnable, // Link on
   input wire logic [4:0] laneCount, // Lanes in use
   input wire logic syncRequestN, // Sync pin
   input wire logic [127:0] laneData, // Lane octets
   input wire logic [15:0] laneIsCtrl, // Control flags
   input wire logic [15:0] laneValid, // Lane flags
   input wire logic bypassLink, // Clock mode
   input wire logic ilaRepeat, // Alignment loop
   input wire logic cgsRequest, // Code group sync
   input wire logic patternActive // Running
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_clock_alternates: assert property (
      bypassLink && $past(bypassLink) |->
      laneData[7:0] == ~$past(laneData[7:0]) &&
      laneData[7:0] inside {8'hff, 8'h00})
      else $error("clock pattern broken");
   a_comma_char: assert property (
      laneIsCtrl[0] |-> laneData[7:0] == 8'hbc && !bypassLink)
      else $error("control octet is not a comma");
   a_ila_no_data: assert property (
      ilaRepeat |-> laneValid == 16'h0)
      else $error("data during alignment loop");
   a_sync_gives_cgs: assert property (
      (ilaRepeat && !syncRequestN) [*7] |-> cgsRequest)
      else $error("no code group sync on request");
   a_cgs_ends: assert property (
      (ilaRepeat && syncRequestN) [*7] |-> !cgsRequest)
      else $error("code group sync does not end");
   a_low_lanes: assert property (
      laneValid != 16'h0 |->
      laneValid == 16'((17'h1 << $past(laneCount)) - 17'h1))
      else $error("wrong lanes carry the pattern");
   a_idle_quiet: assert property (
      !patternActive && !ilaRepeat |-> laneValid == 16'h0 && !bypassLink)
      else $error("pattern outside run state");
   a_clock_held: assert property (
      linkEnable [*4] ##0 bypassLink |=> bypassLink)
      else $error("clock mode left while link on");

   c_clock: cover property (bypassLink ##1 bypassLink);
   c_cgs: cover property (cgsRequest);
   c_comma: cover property (laneIsCtrl[0]);
endmodule

bind sltp_gen sltp_monitor mon_u (.clk(clk), .rst(rst),
   .linkEnable(linkEnable), .laneCount(laneCount),
   .syncRequestN(syncRequestN), .laneData(laneData),
   .laneIsCtrl(laneIsCtrl), .laneValid(laneValid), .bypassLink(bypassLink),
   .ilaRepeat(ilaRepeat), .cgsRequest(cgsRequest),
   .patternActive(patternActive));
`default_nettype wire

// ### tb/sltp_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module sltp_rx_model (
   input wire logic clk, // Clock
   input wire logic loseSync, // Bench asks for a resync
   output logic syncRequestN // Sync pin, low active
);
   // Pin moves well off the edge, as an unrelated receiver would
   always @(posedge clk) syncRequestN <= #13 !loseSync;
endmodule
`default_nettype wire
